// ---- hdl/fba_pkg.sv ----
// constants and types for the flash bus host controller
// Behaviour
// (RULE1) width select high: sixteen data pins active, gated by chip select and output enable.
// (RULE2) width select low: low byte only; top data pin is lowest address bit.
// (RULE3) chip select high puts the device in standby, data pins released.
// (RULE4) chip select or output enable high: device data outputs released.
// (RULE5) after power-up the device reads array contents without any command.
// (RULE6) finished program or erase returns the device to array reads.
// (RULE7) erase-suspend reads inside suspended sectors return status, elsewhere array data.
// (RULE8) host issues reset command after fault flag high or in identification mode.
// (RULE9) high-voltage id: elevate id pin, set selector pins, then read code.
// (RULE10) manufacturer read with upper select low gives continuation code; reread with it high.
// (RULE11) protection verify: sector on top address bits, select pair one-zero; 01h or 00h.
// (RULE12) id codes readable by command sequence with no elevated voltage.
// (RULE13) command identification keeps the id pin at normal logic level.
// (RULE14) read is cs, oe low, we high; write is cs, we low, oe high.
// (RULE15) hardware reset low releases all device data outputs.
// (RULE16) select pair zero gives manufacturer code, bit0 high gives device code.
// (RULE17) address taken on later falling strobe edge, data on earlier rising edge.
// (RULE18) any wrong command sequence returns the device to array reads.
// (RULE19) cs, we and oe all low counts as a read; host avoids it.
package fba_pkg;
    localparam int FBA_ADDR_W = 18;
    localparam int FBA_DATA_W = 16;
    localparam int FBA_CLK_MHZ = 25;
    localparam int FBA_ACC_NS = 90;
    localparam int FBA_ACC_CYC = (FBA_ACC_NS * FBA_CLK_MHZ + 999) / 1000;
    localparam int FBA_WP_NS = 35;
    localparam int FBA_WP_CYC = (FBA_WP_NS * FBA_CLK_MHZ + 999) / 1000;
    localparam int FBA_CNT_W = 4;
    localparam logic [FBA_ADDR_W-1:0] FBA_UNLOCK1 = 18'h00555;
    localparam logic [FBA_ADDR_W-1:0] FBA_UNLOCK2 = 18'h002AA;
    localparam logic [7:0] FBA_CMD_AA = 8'hAA;
    localparam logic [7:0] FBA_CMD_55 = 8'h55;
    localparam logic [7:0] FBA_CMD_ID = 8'h90;
    localparam logic [7:0] FBA_CMD_RESET = 8'hF0;
    localparam int FBA_SEL0_BIT = 0;
    localparam int FBA_SEL1_BIT = 1;
    localparam int FBA_MID_BIT = 6;
    localparam int FBA_UPPER_BIT = 8;
    localparam int FBA_HV_BIT = 9;
    localparam int FBA_SA_LSB = 12;
    localparam logic [1:0] FBA_SEL_MFR = 2'h0;
    localparam logic [1:0] FBA_SEL_DEV = 2'h1;
    localparam logic [1:0] FBA_SEL_PROT = 2'h2;
    localparam logic [7:0] FBA_PROT_YES = 8'h01;
    localparam logic [7:0] FBA_PROT_NO = 8'h00;
    localparam logic [2:0] FBA_OP_READ = 3'h0;
    localparam logic [2:0] FBA_OP_WRITE = 3'h1;
    localparam logic [2:0] FBA_OP_HV_ID = 3'h2;
    localparam logic [2:0] FBA_OP_CMD_ID = 3'h3;
    localparam logic [2:0] FBA_OP_RESET = 3'h4;
    localparam logic [2:0] FBA_OP_HWRST = 3'h5;
    typedef enum logic [1:0] {FBA_CYC_IDLE, FBA_CYC_SETUP, FBA_CYC_HOLD, FBA_CYC_DONE} fba_cyc_t;
    typedef enum logic [2:0] {FBA_SQ_IDLE, FBA_SQ_RUN, FBA_SQ_WAIT, FBA_SQ_RELOAD, FBA_SQ_END} fba_sq_t;
endpackage

// ---- hdl/fba_cyc_if.sv ----
// bundle between sequencer and single bus cycle engine
`timescale 1ns/10ps
interface fba_cyc_if;
    import fba_pkg::*;
    logic start;
    logic wr;
    logic [FBA_ADDR_W-1:0] addr;
    logic [FBA_DATA_W-1:0] wdata;
    logic hv;
    logic done;
    logic [FBA_DATA_W-1:0] rdata;
    modport seq (output start, wr, addr, wdata, hv, input done, rdata);
    modport eng (input start, wr, addr, wdata, hv, output done, rdata);
endinterface

// ---- hdl/fba_cycle.sv ----
// one bus cycle on the flash pins: read or write with strobe timing
`timescale 1ns/10ps
module fba_cycle
    import fba_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic word_mode_in,
    input wire logic [FBA_DATA_W-1:0] dq_in,
    fba_cyc_if.eng c,
    output logic cs_n,
    output logic oe_n,
    output logic we_n,
    output logic [FBA_ADDR_W-1:0] addr,
    output logic lsb_addr,
    output logic [FBA_DATA_W-1:0] dq_o,
    output logic [FBA_DATA_W-1:0] dq_oe_n,
    output logic hv_req
);
    fba_cyc_t st, next_st;
    logic [FBA_CNT_W-1:0] cnt, next_cnt;
    logic wr, next_wr;
    logic next_cs_n, next_oe_n, next_we_n, next_lsb, next_hv, next_done;
    logic [FBA_ADDR_W-1:0] next_addr;
    logic [FBA_DATA_W-1:0] next_dq_o, next_dq_oe_n, next_rdata;
    logic done;
    logic [FBA_DATA_W-1:0] rdata;
    assign c.done = done;
    assign c.rdata = rdata;
    always_comb begin
        next_st = st;
        next_cnt = cnt;
        next_wr = wr;
        next_cs_n = cs_n;
        next_oe_n = oe_n;
        next_we_n = we_n;
        next_addr = addr;
        next_lsb = lsb_addr;
        next_hv = hv_req;
        next_dq_o = dq_o;
        next_dq_oe_n = dq_oe_n;
        next_rdata = rdata;
        next_done = 1'b0;
        case (st)
            FBA_CYC_IDLE: begin
                if (c.start) begin
                    next_wr = c.wr;
                    next_hv = c.hv;
                    // byte mode: top data pin carries lowest address bit
                    // elevated-voltage id addresses come in pin form, so they are not shifted
                    next_addr = (word_mode_in || c.hv) ? c.addr : (c.addr >> 1); // (RULE2)
                    next_lsb = c.addr[0];
                    next_cs_n = 1'b0;
                    // write data goes out a cycle ahead of the strobe and holds past it
                    if (c.wr) begin
                        next_dq_o = c.wdata;
                        next_dq_oe_n = word_mode_in ? {FBA_DATA_W{1'b0}} : 16'h7F00; // (RULE2)
                    end
                    next_st = FBA_CYC_SETUP;
                end
            end
            FBA_CYC_SETUP: begin
                // address settles before strobe; oe stays high on writes
                if (wr) begin
                    next_we_n = 1'b0; // (RULE14) (RULE17)
                    next_cnt = FBA_CNT_W'(FBA_WP_CYC);
                end else begin
                    next_oe_n = 1'b0; // (RULE14) (RULE19)
                    next_dq_oe_n = word_mode_in ? {FBA_DATA_W{1'b1}} : 16'h7FFF;
                    next_cnt = FBA_CNT_W'(FBA_ACC_CYC);
                end
                next_st = FBA_CYC_HOLD;
            end
            FBA_CYC_HOLD: begin
                if (cnt != '0) begin
                    next_cnt = cnt - 1'b1;
                end else begin
                    if (!wr) begin
                        next_rdata = word_mode_in ? dq_in : {8'h00, dq_in[7:0]}; // (RULE1)
                    end
                    // we rises first so the device takes data there
                    next_we_n = 1'b1; // (RULE17)
                    next_oe_n = 1'b1; // (RULE4)
                    next_st = FBA_CYC_DONE;
                end
            end
            FBA_CYC_DONE: begin
                next_cs_n = 1'b1; // (RULE3)
                // elevated id voltage never outlasts its own cycle
                next_hv = 1'b0; // (RULE13)
                next_dq_oe_n = word_mode_in ? {FBA_DATA_W{1'b1}} : 16'h7FFF;
                next_done = 1'b1;
                next_st = FBA_CYC_IDLE;
            end
            default: next_st = FBA_CYC_IDLE;
        endcase
    end
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            st <= FBA_CYC_IDLE;
            cnt <= '0;
            wr <= 1'b0;
            cs_n <= 1'b1;
            oe_n <= 1'b1;
            we_n <= 1'b1;
            addr <= '0;
            lsb_addr <= 1'b0;
            hv_req <= 1'b0;
            dq_o <= '0;
            dq_oe_n <= {FBA_DATA_W{1'b1}};
            rdata <= '0;
            done <= 1'b0;
        end else begin
            st <= next_st;
            cnt <= next_cnt;
            wr <= next_wr;
            cs_n <= next_cs_n;
            oe_n <= next_oe_n;
            we_n <= next_we_n;
            addr <= next_addr;
            lsb_addr <= next_lsb;
            hv_req <= next_hv;
            dq_o <= next_dq_o;
            dq_oe_n <= next_dq_oe_n;
            rdata <= next_rdata;
            done <= next_done;
        end
    end
endmodule

// ---- hdl/fba_host.sv ----
// host controller: read, write, identification and reset sequences
`timescale 1ns/10ps
module fba_host
    import fba_pkg::*;
#(
    parameter int HWRST_CYC = 13
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic word_mode_in,
    input wire logic req_in,
    input wire logic [2:0] op_in,
    input wire logic [FBA_ADDR_W-1:0] addr_in,
    input wire logic [FBA_DATA_W-1:0] wdata_in,
    input wire logic [1:0] id_sel_in,
    input wire logic [FBA_DATA_W-1:0] flash_dq_in,
    output logic busy_out,
    output logic done_out,
    output logic [FBA_DATA_W-1:0] rdata_out,
    output logic flash_cs_n_out,
    output logic flash_oe_n_out,
    output logic flash_we_n_out,
    output logic flash_rst_n_out,
    output logic flash_word_mode_out,
    output logic flash_hv_id_out,
    output logic [FBA_ADDR_W-1:0] flash_addr_out,
    output logic [FBA_DATA_W-1:0] flash_dq_out,
    output logic [FBA_DATA_W-1:0] flash_dq_oe_n_out
);
    if (HWRST_CYC < 1 || HWRST_CYC > 65535) begin : g_hwrst_chk
        $error("HWRST_CYC out of range");
    end
    fba_cyc_if c();
    logic cs_n, oe_n, we_n, lsb, hv;
    logic [FBA_ADDR_W-1:0] caddr;
    logic [FBA_DATA_W-1:0] cdq, cdq_oe_n;
    fba_cycle u_cyc (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .word_mode_in(flash_word_mode_out),
        .dq_in(flash_dq_in),
        .c(c.eng),
        .cs_n(cs_n),
        .oe_n(oe_n),
        .we_n(we_n),
        .addr(caddr),
        .lsb_addr(lsb),
        .dq_o(cdq),
        .dq_oe_n(cdq_oe_n),
        .hv_req(hv)
    );
    fba_sq_t st, next_st;
    logic [2:0] op, next_op;
    logic [2:0] step, next_step;
    logic [FBA_ADDR_W-1:0] addr, next_addr;
    logic [FBA_DATA_W-1:0] wdata, next_wdata;
    logic [1:0] sel, next_sel;
    logic upper, next_upper;
    logic [15:0] rcnt, next_rcnt;
    logic start, next_start;
    logic next_busy, next_done, next_rst_n;
    logic [FBA_DATA_W-1:0] next_rdata;
    logic [FBA_ADDR_W-1:0] id_addr;
    logic [FBA_ADDR_W-1:0] s_addr;
    logic [7:0] s_data;
    logic s_wr, s_hv, s_last;
    logic next_wm;
    assign next_wm = busy_out ? flash_word_mode_out : word_mode_in;
    assign c.start = start;
    assign c.addr = s_addr;
    assign c.wdata = {8'h00, s_data} | (s_wr && op == FBA_OP_WRITE ? wdata : '0);
    assign c.wr = s_wr;
    assign c.hv = s_hv;
    // selector pins for the wanted code; sector address kept on top bits
    always_comb begin
        id_addr = addr;
        id_addr[FBA_SEL0_BIT] = sel[0]; // (RULE16) (RULE11)
        id_addr[FBA_SEL1_BIT] = sel[1]; // (RULE11)
        id_addr[FBA_MID_BIT] = 1'b0; // (RULE9)
        id_addr[FBA_UPPER_BIT] = upper; // (RULE10)
        id_addr[FBA_HV_BIT] = 1'b0; // (RULE13)
    end
    // step decoding of the pin cycles each operation needs
    always_comb begin
        s_addr = addr;
        s_data = 8'h00;
        s_wr = 1'b0;
        s_hv = 1'b0;
        s_last = 1'b1;
        case (op)
            FBA_OP_WRITE: s_wr = 1'b1; // (RULE14)
            FBA_OP_HV_ID: begin
                s_addr = id_addr;
                s_hv = 1'b1; // (RULE9)
            end
            FBA_OP_CMD_ID: begin
                // unlock, unlock, id command, code read, reset command
                s_last = (step == 3'h4);
                case (step)
                    3'h0: begin s_wr = 1'b1; s_addr = FBA_UNLOCK1; s_data = FBA_CMD_AA; end
                    3'h1: begin s_wr = 1'b1; s_addr = FBA_UNLOCK2; s_data = FBA_CMD_55; end
                    3'h2: begin s_wr = 1'b1; s_addr = FBA_UNLOCK1; s_data = FBA_CMD_ID; end // (RULE12)
                    3'h3: s_addr = id_addr; // (RULE13)
                    default: begin s_wr = 1'b1; s_data = FBA_CMD_RESET; end // (RULE8)
                endcase
            end
            FBA_OP_RESET: begin
                s_wr = 1'b1;
                s_data = FBA_CMD_RESET; // (RULE8) (RULE18)
            end
            default: s_wr = 1'b0;
        endcase
    end
    always_comb begin
        next_st = st;
        next_op = op;
        next_step = step;
        next_addr = addr;
        next_wdata = wdata;
        next_sel = sel;
        next_upper = upper;
        next_rcnt = rcnt;
        next_start = 1'b0;
        next_busy = busy_out;
        next_done = 1'b0;
        next_rst_n = flash_rst_n_out;
        next_rdata = rdata_out;
        case (st)
            FBA_SQ_IDLE: begin
                if (req_in) begin
                    next_op = op_in;
                    next_addr = addr_in;
                    next_wdata = wdata_in;
                    next_sel = id_sel_in;
                    // manufacturer code is read with upper select high
                    next_upper = (id_sel_in == FBA_SEL_MFR); // (RULE10)
                    next_step = '0;
                    next_busy = 1'b1;
                    if (op_in == FBA_OP_HWRST) begin
                        next_rst_n = 1'b0; // (RULE15)
                        next_rcnt = 16'(HWRST_CYC);
                        next_st = FBA_SQ_WAIT;
                    end else begin
                        next_start = 1'b1;
                        next_st = FBA_SQ_RUN;
                    end
                end
            end
            FBA_SQ_RUN: begin
                if (c.done) begin
                    if (!s_wr) begin
                        next_rdata = c.rdata;
                    end
                    if (s_last) begin
                        next_st = FBA_SQ_END;
                    end else begin
                        next_step = step + 3'h1;
                        next_st = FBA_SQ_RELOAD;
                    end
                end
            end
            FBA_SQ_RELOAD: begin
                next_start = 1'b1;
                next_st = FBA_SQ_RUN;
            end
            FBA_SQ_WAIT: begin
                if (rcnt != '0) begin
                    next_rcnt = rcnt - 16'h0001;
                end else begin
                    next_rst_n = 1'b1; // (RULE5)
                    next_st = FBA_SQ_END;
                end
            end
            FBA_SQ_END: begin
                next_busy = 1'b0;
                next_done = 1'b1;
                next_st = FBA_SQ_IDLE;
            end
            default: next_st = FBA_SQ_IDLE;
        endcase
    end
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            st <= FBA_SQ_IDLE;
            op <= FBA_OP_READ;
            step <= '0;
            addr <= '0;
            wdata <= '0;
            sel <= '0;
            upper <= 1'b0;
            rcnt <= '0;
            start <= 1'b0;
            busy_out <= 1'b0;
            done_out <= 1'b0;
            flash_rst_n_out <= 1'b1;
            rdata_out <= '0;
        end else begin
            st <= next_st;
            op <= next_op;
            step <= next_step;
            addr <= next_addr;
            wdata <= next_wdata;
            sel <= next_sel;
            upper <= next_upper;
            rcnt <= next_rcnt;
            start <= next_start;
            busy_out <= next_busy;
            done_out <= next_done;
            flash_rst_n_out <= next_rst_n;
            rdata_out <= next_rdata;
        end
    end
    // pin outputs other than the width pin come from the engine flops; width pin from word_mode_in while idle; merged lsb onto top data pin in byte mode
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            flash_cs_n_out <= 1'b1;
            flash_oe_n_out <= 1'b1;
            flash_we_n_out <= 1'b1;
            flash_word_mode_out <= 1'b1;
            flash_hv_id_out <= 1'b0;
            flash_addr_out <= '0;
            flash_dq_out <= '0;
            flash_dq_oe_n_out <= {FBA_DATA_W{1'b1}};
        end else begin
            flash_cs_n_out <= cs_n;
            flash_oe_n_out <= oe_n;
            flash_we_n_out <= we_n;
            if (!busy_out) begin
                flash_word_mode_out <= word_mode_in; // (RULE1) (RULE2)
            end
            flash_hv_id_out <= hv; // (RULE9)
            flash_addr_out <= caddr;
            flash_dq_out <= flash_word_mode_out ? cdq : {lsb, cdq[14:0]}; // (RULE2)
            flash_dq_oe_n_out[14:0] <= cdq_oe_n[14:0];
            // top pin stays driven in byte mode even while idle; in word mode it follows pin 14, driven only on writes
            flash_dq_oe_n_out[15] <= next_wm & cdq_oe_n[14]; // (RULE2)
        end
    end
endmodule

// ---- tb/fba_host_chk.sv ----
// pin-level assertions for the flash host controller
`timescale 1ns/10ps
module fba_host_chk
    import fba_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic req_in,
    input wire logic [2:0] op_in,
    input wire logic busy_out,
    input wire logic done_out,
    input wire logic flash_cs_n_out,
    input wire logic flash_oe_n_out,
    input wire logic flash_we_n_out,
    input wire logic flash_rst_n_out,
    input wire logic flash_word_mode_out,
    input wire logic flash_hv_id_out,
    input wire logic [FBA_ADDR_W-1:0] flash_addr_out,
    input wire logic [FBA_DATA_W-1:0] flash_dq_out,
    input wire logic [FBA_DATA_W-1:0] flash_dq_oe_n_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);
    logic take;
    assign take = req_in && !busy_out;
    AST_TAKE_BUSY: assert property (take |-> ##[1:2] busy_out)
        else $error("busy not raised");
    AST_DONE_BOUND: assert property (take |-> ##[2:200] done_out)
        else $error("no completion");
    AST_DONE_PULSE: assert property (done_out |=> !done_out)
        else $error("done too long");
    AST_NOT_ALL_LOW: assert property (flash_cs_n_out || flash_oe_n_out || flash_we_n_out)
        else $error("strobes all low");
    AST_WRITE_FORM: assert property (!flash_we_n_out |-> !flash_cs_n_out && flash_oe_n_out
        && (!flash_word_mode_out || flash_dq_oe_n_out == 16'h0000))
        else $error("bad write cycle");
    AST_READ_RELEASE: assert property (!flash_oe_n_out |-> flash_we_n_out
        && (&flash_dq_oe_n_out[14:0]))
        else $error("host drives during read");
    AST_BYTE_PINS: assert property (!flash_word_mode_out |-> flash_dq_oe_n_out[15:8] == 8'h7F)
        else $error("byte mode pin enables wrong");
    AST_WR_SETUP: assert property (!flash_we_n_out |-> $stable(flash_addr_out)
        && $stable(flash_dq_out))
        else $error("write address or data moved");
    AST_HV_CMD: assert property (take && op_in == FBA_OP_CMD_ID |=> !flash_hv_id_out [*8])
        else $error("id voltage in command id");
    AST_HV_SEL: assert property (flash_hv_id_out && !flash_oe_n_out |->
        !flash_addr_out[FBA_MID_BIT] && $past(flash_hv_id_out))
        else $error("id read setup wrong");
    AST_HV_UPPER: assert property (flash_hv_id_out && !flash_oe_n_out
        && flash_addr_out[1:0] == FBA_SEL_MFR |-> flash_addr_out[FBA_UPPER_BIT])
        else $error("maker read with upper select low");
    CVR_HV_ID: cover property (take && op_in == FBA_OP_HV_ID);
    CVR_CMD_ID: cover property (take && op_in == FBA_OP_CMD_ID);
    CVR_HWRST: cover property (!flash_rst_n_out);
endmodule
bind fba_host fba_host_chk fba_host_chk_i (.*);

// ---- tb/fba_flash_model.sv ----
// behavioural model of the flash device on the host pins
`timescale 1ns/10ps
module fba_flash_model
    import fba_pkg::*;
#(
    parameter logic [7:0] MFR_CODE = 8'h5A, // arbitrary value
    parameter logic [7:0] CONT_CODE = 8'hA5, // arbitrary value
    parameter logic [15:0] DEV_CODE = 16'h3C96 // arbitrary value
) (
    input wire logic cs_n_in,
    input wire logic oe_n_in,
    input wire logic we_n_in,
    input wire logic rst_n_in,
    input wire logic word_in,
    input wire logic hv_in,
    input wire logic [FBA_ADDR_W-1:0] addr_in,
    input wire logic [FBA_DATA_W-1:0] dq_in,
    output logic [FBA_DATA_W-1:0] dq_out,
    output logic [FBA_DATA_W-1:0] dq_en_out
);
    logic id_mode = 1'b0;
    logic [1:0] step = 2'h0;
    logic [FBA_ADDR_W-1:0] wa;
    logic [15:0] w;
    logic [15:0] code;
    wire wr_act = !cs_n_in && !we_n_in && oe_n_in && rst_n_in;
    wire rd_act = !cs_n_in && !oe_n_in && rst_n_in;
    always @(posedge wr_act) wa = addr_in;
    // commands act on the first rising strobe, data taken there
    always @(negedge wr_act) begin
        if (dq_in[7:0] == FBA_CMD_RESET) begin
            id_mode = 1'b0;
            step = 2'h0;
        end else if (step == 2'h0 && wa == FBA_UNLOCK1 && dq_in[7:0] == FBA_CMD_AA) begin
            step = 2'h1;
        end else if (step == 2'h1 && wa == FBA_UNLOCK2 && dq_in[7:0] == FBA_CMD_55) begin
            step = 2'h2;
        end else if (step == 2'h2 && wa == FBA_UNLOCK1 && dq_in[7:0] == FBA_CMD_ID) begin
            id_mode = 1'b1;
            step = 2'h0;
        end else begin
            id_mode = 1'b0;
            step = 2'h0;
        end
    end
    always @(negedge rst_n_in) begin
        id_mode = 1'b0;
        step = 2'h0;
    end
    always_comb begin
        case (addr_in[1:0])
            FBA_SEL_MFR: code = {8'h00, addr_in[FBA_UPPER_BIT] ? MFR_CODE : CONT_CODE};
            FBA_SEL_DEV: code = DEV_CODE;
            FBA_SEL_PROT: code = {8'h00, addr_in[FBA_SA_LSB] ? FBA_PROT_YES : FBA_PROT_NO};
            default: code = 16'h0000;
        endcase
        // no erase is ever suspended here, so every sector reads array data
        w = (hv_in || id_mode) ? code : {~addr_in[7:0], addr_in[15:8]};
        // in byte mode the top data pin is the byte select, codes ignore it
        dq_out = word_in ? w : {8'h00, (dq_in[15] && !(hv_in || id_mode)) ? w[15:8] : w[7:0]};
        dq_en_out = !rd_act ? 16'h0000 : (word_in ? 16'hFFFF : 16'h00FF);
    end
endmodule

// ---- tb/tb.sv ----
// self-checking bench: host controller against the flash model
`timescale 1ns/10ps
module tb;
    import fba_pkg::*;
    localparam logic [7:0] MFR = 8'h5A; // arbitrary value
    localparam logic [7:0] CONT = 8'hA5; // arbitrary value
    localparam logic [15:0] DEV = 16'h3C96; // arbitrary value
    logic mclk_in = 1'b0, rst_in = 1'b1, word_mode_in = 1'b1, req_in = 1'b0, tick = 1'b0;
    logic [2:0] op_in = 3'h0;
    logic [1:0] id_sel_in = 2'h0;
    logic [FBA_ADDR_W-1:0] addr_in = 18'h00000, a, flash_addr_out;
    logic [FBA_DATA_W-1:0] wdata_in = 16'h0000, flash_dq_in, rdata_out, flash_dq_out;
    logic [FBA_DATA_W-1:0] flash_dq_oe_n_out, dev_dq, dev_en;
    logic busy_out, done_out, flash_cs_n_out, flash_oe_n_out, flash_we_n_out;
    logic flash_rst_n_out, flash_word_mode_out, flash_hv_id_out;
    logic [16:0] exp_q[$];
    int error_cnt = 0, check_count = 0, seed = 903, n;
    initial begin
        forever #20 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in) tick <= ~tick;
    // released bits toggle so a stale value never reads as valid
    assign flash_dq_in = (~flash_dq_oe_n_out & flash_dq_out) | (flash_dq_oe_n_out & dev_en & dev_dq)
        | (flash_dq_oe_n_out & ~dev_en & {8{tick, ~tick}});
    fba_host #(.HWRST_CYC(13)) fba_host_i (.mclk_in(mclk_in), .rst_in(rst_in),
        .word_mode_in(word_mode_in), .req_in(req_in), .op_in(op_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .id_sel_in(id_sel_in), .flash_dq_in(flash_dq_in),
        .busy_out(busy_out), .done_out(done_out), .rdata_out(rdata_out),
        .flash_cs_n_out(flash_cs_n_out), .flash_oe_n_out(flash_oe_n_out),
        .flash_we_n_out(flash_we_n_out), .flash_rst_n_out(flash_rst_n_out),
        .flash_word_mode_out(flash_word_mode_out), .flash_hv_id_out(flash_hv_id_out),
        .flash_addr_out(flash_addr_out), .flash_dq_out(flash_dq_out),
        .flash_dq_oe_n_out(flash_dq_oe_n_out));
    fba_flash_model #(.MFR_CODE(MFR), .CONT_CODE(CONT), .DEV_CODE(DEV)) fba_flash_model_i (
        .cs_n_in(flash_cs_n_out), .oe_n_in(flash_oe_n_out), .we_n_in(flash_we_n_out),
        .rst_n_in(flash_rst_n_out), .word_in(flash_word_mode_out), .hv_in(flash_hv_id_out),
        .addr_in(flash_addr_out), .dq_in(flash_dq_in), .dq_out(dev_dq), .dq_en_out(dev_en));
    function automatic logic [15:0] arr(input logic [17:0] wa);
        return {~wa[7:0], wa[15:8]};
    endfunction
    function automatic logic [16:0] barr(input logic [17:0] ba);
        logic [15:0] t;
        t = arr(ba >> 1);
        return {9'h100, ba[0] ? t[15:8] : t[7:0]};
    endfunction
    task automatic wrap_up;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic fail(input string m);
        error_cnt++;
        $display("[ERR] %0t %s", $time, m);
        wrap_up();
    endtask
    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t read %h expected %h", $time, got, exp);
        end
    endtask
    task automatic do_op(input logic [2:0] op, input logic [17:0] ad, input logic [15:0] d,
        input logic [1:0] sel, input logic [16:0] ex);
        int k;
        for (k = 0; busy_out !== 1'b0; k++) begin
            if (k > 400) fail("busy stuck");
            @(posedge mclk_in);
            #1;
        end
        exp_q.push_back(ex);
        op_in = op;
        addr_in = ad;
        wdata_in = d;
        id_sel_in = sel;
        req_in = 1'b1;
        @(posedge mclk_in);
        #1;
        req_in = 1'b0;
        for (k = 0; done_out !== 1'b1; k++) begin
            if (k > 400) fail("no done");
            @(posedge mclk_in);
            #1;
        end
    endtask
    task automatic set_width(input logic m);
        word_mode_in = m;
        repeat (2) @(posedge mclk_in);
        #1;
    endtask
    task automatic enter_id;
        do_op(FBA_OP_WRITE, FBA_UNLOCK1, 16'h00AA, 2'h0, 17'h0);
        do_op(FBA_OP_WRITE, FBA_UNLOCK2, 16'h0055, 2'h0, 17'h0);
        do_op(FBA_OP_WRITE, FBA_UNLOCK1, 16'h0090, 2'h0, 17'h0);
    endtask
    // results are checked in order as each done pulse appears
    always @(posedge mclk_in) begin
        if (done_out === 1'b1) begin
            if (exp_q.size() == 0) fail("unexpected done");
            else if (exp_q[0][16]) cmp16(rdata_out, exp_q[0][15:0]);
            if (exp_q.size() != 0) void'(exp_q.pop_front());
        end
    end
    initial begin
        repeat (16) @(posedge mclk_in);
        #1;
        rst_in = 1'b0;
        for (n = 0; n < 4; n++) begin
            a = 18'($random(seed));
            do_op(FBA_OP_READ, a, 16'h0000, 2'h0, {1'b1, arr(a)});
        end
        set_width(1'b0);
        for (n = 0; n < 4; n++) begin
            a = 18'($random(seed));
            do_op(FBA_OP_READ, a, 16'h0000, 2'h0, barr(a));
        end
        do_op(FBA_OP_HV_ID, 18'h00000, 16'h0000, FBA_SEL_MFR, {9'h100, MFR});
        do_op(FBA_OP_HV_ID, 18'h00000, 16'h0000, FBA_SEL_DEV, {9'h100, DEV[7:0]});
        $display("byte mode test done");
        set_width(1'b1);
        do_op(FBA_OP_HV_ID, 18'h00000, 16'h0000, FBA_SEL_MFR, {9'h100, MFR});
        do_op(FBA_OP_HV_ID, 18'h00000, 16'h0000, FBA_SEL_DEV, {1'b1, DEV});
        do_op(FBA_OP_HV_ID, 18'h01000, 16'h0000, FBA_SEL_PROT, 17'h10001);
        do_op(FBA_OP_HV_ID, 18'h00000, 16'h0000, FBA_SEL_PROT, 17'h10000);
        do_op(FBA_OP_CMD_ID, 18'h00000, 16'h0000, FBA_SEL_MFR, {9'h100, MFR});
        do_op(FBA_OP_CMD_ID, 18'h00000, 16'h0000, FBA_SEL_DEV, {1'b1, DEV});
        do_op(FBA_OP_READ, 18'h00123, 16'h0000, 2'h0, {1'b1, arr(18'h00123)});
        $display("identification test done");
        enter_id();
        do_op(FBA_OP_READ, 18'h00100, 16'h0000, 2'h0, {9'h100, MFR});
        do_op(FBA_OP_READ, 18'h00000, 16'h0000, 2'h0, {9'h100, CONT});
        do_op(FBA_OP_RESET, 18'h00000, 16'h0000, 2'h0, 17'h0);
        do_op(FBA_OP_READ, 18'h00100, 16'h0000, 2'h0, {1'b1, arr(18'h00100)});
        enter_id();
        do_op(FBA_OP_WRITE, 18'h00000, 16'h0012, 2'h0, 17'h0);
        do_op(FBA_OP_READ, 18'h00100, 16'h0000, 2'h0, {1'b1, arr(18'h00100)});
        enter_id();
        do_op(FBA_OP_HWRST, 18'h00000, 16'h0000, 2'h0, 17'h0);
        do_op(FBA_OP_READ, 18'h00101, 16'h0000, 2'h0, {1'b1, arr(18'h00101)});
        $display("command test done");
        repeat (3) @(posedge mclk_in);
        wrap_up();
    end
endmodule
